// ===== design/uart_autobaud_break_wakeup.sv
`timescale 1ns/1ps
`include "uart_ab_params.svh"

module uart_autobaud_break_wakeup #(
    parameter int BUF_DEPTH = `TX_BUF_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic rx_line,
    output logic tx_line,
    input wire logic autobaud_arm_set,
    input wire logic autobaud_arm_clr,
    input wire logic wake_arm_set,
    input wire logic wake_arm_clr,
    input wire logic break_send_set,
    input wire logic transmit_enable,
    input wire logic wide_divisor_sel,
    input wire logic high_speed_sel,
    input wire logic divisor_wr,
    input wire logic [15:0] divisor_wdata,
    input wire logic overflow_clr,
    input wire logic receive_data_rd,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data,
    output logic autobaud_arm,
    output logic wake_arm,
    output logic break_send,
    output logic autobaud_overflow,
    output logic receive_flag,
    output logic receiver_idle,
    output logic [15:0] divisor,
    output logic [7:0] receive_data_reg,
    output logic shift_empty,
    output logic transmit_flag
);

    // ****************************************************************
    // line edges and divider timing
    // ****************************************************************
    logic rx_prev_q;
    logic rx_fall;
    logic rx_rise;
    logic [4:0] base_shift;
    logic [23:0] bit_cycles;
    logic [8:0] abd_len;
    logic [8:0] pre_q;
    logic abd_tick;

    assign rx_fall = rx_prev_q && !rx_line;
    assign rx_rise = !rx_prev_q && rx_line;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rx_prev_q <= 1'b1;
        end else begin
            rx_prev_q <= rx_line;
        end
    end

    always_comb begin
        if (!wide_divisor_sel && !high_speed_sel) begin
            base_shift = `BASE_SHIFT_SLOW;
        end else if (wide_divisor_sel && high_speed_sel) begin
            base_shift = `BASE_SHIFT_FAST;
        end else begin
            base_shift = `BASE_SHIFT_MID;
        end
    end

    // full 16-bit divisor always used; narrow mode only changes the base shift, the high half is not cleared
    assign bit_cycles = 24'(({8'h00, divisor} + 24'h00_0001) << base_shift);
    assign abd_len = 9'(10'h001 << (base_shift + `ABD_EXTRA_SHIFT));

    // ****************************************************************
    // calibration state
    // ****************************************************************
    uart_ab_pkg::abd_state_t abd_q;
    logic [2:0] rise_cnt_q;
    logic abd_done;
    logic abd_ovf_evt;
    logic abd_busy;

    assign abd_busy = (abd_q != uart_ab_pkg::ABD_OFF);
    assign abd_tick = (abd_q == uart_ab_pkg::ABD_COUNT) && (pre_q == abd_len - 9'h001);
    assign abd_done = (abd_q == uart_ab_pkg::ABD_COUNT) && rx_rise
        && (rise_cnt_q == `ABD_LAST_RISE - 3'h1);
    assign abd_ovf_evt = abd_tick && (divisor == `DIVISOR_MAX) && !abd_done;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            abd_q <= uart_ab_pkg::ABD_OFF;
            rise_cnt_q <= 3'h0;
        end else if (!autobaud_arm) begin
            abd_q <= uart_ab_pkg::ABD_OFF;
            rise_cnt_q <= 3'h0;
        end else begin
            case (abd_q)
                uart_ab_pkg::ABD_OFF: begin
                    // a pending wake pushes calibration to the byte after the break
                    if (!wake_arm) begin
                        abd_q <= uart_ab_pkg::ABD_START;
                    end
                end
                uart_ab_pkg::ABD_START: begin
                    if (rx_fall) begin
                        abd_q <= uart_ab_pkg::ABD_FIRST;
                    end
                end
                uart_ab_pkg::ABD_FIRST: begin
                    if (rx_rise) begin
                        abd_q <= uart_ab_pkg::ABD_COUNT;
                        rise_cnt_q <= 3'h1;
                    end
                end
                uart_ab_pkg::ABD_COUNT: begin
                    if (abd_done) begin
                        abd_q <= uart_ab_pkg::ABD_OFF;
                        rise_cnt_q <= 3'h0;
                    end else if (rx_rise) begin
                        rise_cnt_q <= rise_cnt_q + 3'h1;
                    end
                end
                default: begin
                    abd_q <= uart_ab_pkg::ABD_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pre_q <= 9'h000;
        end else if (abd_q != uart_ab_pkg::ABD_COUNT || abd_tick) begin
            pre_q <= 9'h000;
        end else begin
            pre_q <= pre_q + 9'h001;
        end
    end

    // divisor pair doubles as the calibration counter
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            divisor <= `DIVISOR_RESET;
        end else if (abd_q == uart_ab_pkg::ABD_FIRST && rx_rise && autobaud_arm) begin
            divisor <= `ABD_COUNT_START;
        end else if (abd_tick && !abd_done) begin
            divisor <= divisor + 16'h0001;
        end else if (divisor_wr && !abd_busy) begin
            divisor <= divisor_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            autobaud_arm <= 1'b0;
        end else if (abd_done) begin
            autobaud_arm <= 1'b0;
        end else if (autobaud_arm_set) begin
            autobaud_arm <= 1'b1;
        end else if (autobaud_arm_clr) begin
            autobaud_arm <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            autobaud_overflow <= 1'b0;
        end else if (abd_ovf_evt) begin
            autobaud_overflow <= 1'b1;
        end else if (overflow_clr) begin
            autobaud_overflow <= 1'b0;
        end
    end

    // ****************************************************************
    // wake on break
    // ****************************************************************
    logic wake_seen_q;
    logic wake_evt;
    logic wake_end;

    assign wake_evt = wake_arm && !wake_seen_q && rx_fall;
    assign wake_end = wake_arm && wake_seen_q && rx_rise;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wake_arm <= 1'b0;
            wake_seen_q <= 1'b0;
        end else begin
            if (wake_end) begin
                wake_arm <= 1'b0;
            end else if (wake_arm_set) begin
                wake_arm <= 1'b1;
            end else if (wake_arm_clr) begin
                wake_arm <= 1'b0;
            end
            if (!wake_arm || wake_end) begin
                wake_seen_q <= 1'b0;
            end else if (wake_evt) begin
                wake_seen_q <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // receiver
    // ****************************************************************
    uart_ab_pkg::rx_state_t rx_q;
    logic [23:0] rx_cnt_q;
    logic [3:0] rx_bit_q;
    logic [7:0] rx_shift_q;
    logic rx_block;
    logic rx_byte_evt;

    assign rx_block = autobaud_arm || wake_arm;
    assign rx_byte_evt = (rx_q == uart_ab_pkg::RX_STOP) && (rx_cnt_q == 24'h00_0000) && !rx_block;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rx_q <= uart_ab_pkg::RX_IDLE;
            rx_cnt_q <= 24'h00_0000;
            rx_bit_q <= 4'h0;
            rx_shift_q <= 8'h00;
        end else if (rx_block) begin
            rx_q <= uart_ab_pkg::RX_IDLE;
        end else begin
            case (rx_q)
                uart_ab_pkg::RX_IDLE: begin
                    if (rx_fall) begin
                        rx_q <= uart_ab_pkg::RX_START;
                        rx_cnt_q <= bit_cycles >> 1;
                    end
                end
                uart_ab_pkg::RX_START: begin
                    if (rx_cnt_q != 24'h00_0000) begin
                        rx_cnt_q <= rx_cnt_q - 24'h00_0001;
                    end else if (!rx_line) begin
                        rx_q <= uart_ab_pkg::RX_DATA;
                        rx_cnt_q <= bit_cycles - 24'h00_0001;
                        rx_bit_q <= 4'h0;
                    end else begin
                        rx_q <= uart_ab_pkg::RX_IDLE;
                    end
                end
                uart_ab_pkg::RX_DATA: begin
                    if (rx_cnt_q != 24'h00_0000) begin
                        rx_cnt_q <= rx_cnt_q - 24'h00_0001;
                    end else begin
                        rx_shift_q <= {rx_line, rx_shift_q[7:1]};
                        rx_cnt_q <= bit_cycles - 24'h00_0001;
                        rx_bit_q <= rx_bit_q + 4'h1;
                        if (rx_bit_q == `DATA_BITS - 4'h1) begin
                            rx_q <= uart_ab_pkg::RX_STOP;
                        end
                    end
                end
                uart_ab_pkg::RX_STOP: begin
                    if (rx_cnt_q != 24'h00_0000) begin
                        rx_cnt_q <= rx_cnt_q - 24'h00_0001;
                    end else begin
                        rx_q <= uart_ab_pkg::RX_IDLE;
                    end
                end
                default: begin
                    rx_q <= uart_ab_pkg::RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            receive_data_reg <= 8'h00;
        end else if (rx_byte_evt) begin
            receive_data_reg <= rx_shift_q;
        end
    end

    // a new event in the read cycle wins, so nothing is lost
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            receive_flag <= 1'b0;
        end else if (abd_done || abd_ovf_evt || wake_evt || rx_byte_evt) begin
            receive_flag <= 1'b1;
        end else if (receive_data_rd) begin
            receive_flag <= 1'b0;
        end
    end

    // one cycle behind the state it reports
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            receiver_idle <= 1'b1;
        end else begin
            receiver_idle <= (abd_q != uart_ab_pkg::ABD_FIRST) && (abd_q != uart_ab_pkg::ABD_COUNT)
                && (rx_q == uart_ab_pkg::RX_IDLE);
        end
    end

    // ****************************************************************
    // transmitter
    // ****************************************************************
    uart_ab_pkg::tx_state_t tx_q;
    logic [13:0] tx_shift_q;
    logic [3:0] tx_left_q;
    logic [23:0] tx_cnt_q;
    logic tx_brk_q;
    logic buf_valid;
    logic [7:0] buf_data;
    logic tx_load;
    logic tx_bit_end;
    logic tx_frame_end;

    assign tx_load = (tx_q == uart_ab_pkg::TX_IDLE) && transmit_enable && buf_valid;
    assign tx_bit_end = (tx_q == uart_ab_pkg::TX_RUN) && (tx_cnt_q == 24'h00_0000);
    assign tx_frame_end = tx_bit_end && (tx_left_q == 4'h1);

    uart_tx_buffer #(
        .WIDTH(8),
        .DEPTH(BUF_DEPTH)
    ) u_tx_buffer (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .in_data(tx_data),
        .out_valid(buf_valid),
        .out_ready(tx_load),
        .out_data(buf_data),
        .empty(transmit_flag)
    );

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tx_q <= uart_ab_pkg::TX_IDLE;
            tx_shift_q <= 14'h3fff;
            tx_left_q <= 4'h0;
            tx_cnt_q <= 24'h00_0000;
            tx_brk_q <= 1'b0;
        end else begin
            case (tx_q)
                uart_ab_pkg::TX_IDLE: begin
                    if (tx_load) begin
                        tx_q <= uart_ab_pkg::TX_RUN;
                        tx_cnt_q <= bit_cycles - 24'h00_0001;
                        tx_brk_q <= break_send;
                        if (break_send) begin
                            // written value dropped, all zeros sent
                            tx_shift_q <= {1'b1, 12'h000, 1'b0};
                            tx_left_q <= `FRAME_BITS_BREAK;
                        end else begin
                            tx_shift_q <= {4'hf, 1'b1, buf_data, 1'b0};
                            tx_left_q <= `FRAME_BITS_NORMAL;
                        end
                    end
                end
                uart_ab_pkg::TX_RUN: begin
                    if (tx_frame_end) begin
                        tx_q <= uart_ab_pkg::TX_IDLE;
                        tx_left_q <= 4'h0;
                        tx_brk_q <= 1'b0;
                    end else if (tx_bit_end) begin
                        tx_shift_q <= {1'b1, tx_shift_q[13:1]};
                        tx_left_q <= tx_left_q - 4'h1;
                        tx_cnt_q <= bit_cycles - 24'h00_0001;
                    end else begin
                        tx_cnt_q <= tx_cnt_q - 24'h00_0001;
                    end
                end
                default: begin
                    tx_q <= uart_ab_pkg::TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tx_line <= 1'b1;
            shift_empty <= 1'b1;
        end else begin
            tx_line <= (tx_q == uart_ab_pkg::TX_RUN) ? tx_shift_q[0] : 1'b1;
            shift_empty <= (tx_q == uart_ab_pkg::TX_IDLE) && !tx_load;
        end
    end

    // queued sync byte goes out only once the break frame has finished
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            break_send <= 1'b0;
        end else if (break_send_set) begin
            break_send <= 1'b1;
        end else if (tx_frame_end && tx_brk_q) begin
            break_send <= 1'b0;
        end
    end

endmodule : uart_autobaud_break_wakeup

// ===== design/uart_ab_params.svh
`ifndef UART_AB_PARAMS_SVH
`define UART_AB_PARAMS_SVH

// ****************************************************************
// divider base clock, as a shift of the system clock
// ****************************************************************
`define BASE_SHIFT_SLOW 5'h06
`define BASE_SHIFT_MID 5'h04
`define BASE_SHIFT_FAST 5'h02
`define ABD_EXTRA_SHIFT 5'h03

// ****************************************************************
// calibration and framing counts
// ****************************************************************
`define ABD_LAST_RISE 3'h5
`define ABD_COUNT_START 16'h0001
`define DIVISOR_MAX 16'hffff
`define DIVISOR_RESET 16'h0000
`define DATA_BITS 4'h8
`define FRAME_BITS_NORMAL 4'ha
`define FRAME_BITS_BREAK 4'he
`define TX_BUF_DEPTH 2

`endif

// ===== design/uart_ab_pkg.sv
package uart_ab_pkg;

    typedef enum logic [3:0] {
        ABD_OFF = 4'h1,
        ABD_START = 4'h2,
        ABD_FIRST = 4'h4,
        ABD_COUNT = 4'h8
    } abd_state_t;

    typedef enum logic [3:0] {
        RX_IDLE = 4'h1,
        RX_START = 4'h2,
        RX_DATA = 4'h4,
        RX_STOP = 4'h8
    } rx_state_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'h1,
        TX_RUN = 2'h2
    } tx_state_t;

endpackage : uart_ab_pkg

// ===== design/uart_tx_buffer.sv
`timescale 1ns/1ps

module uart_tx_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic empty
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr_q];

    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + CW'(1);
        end else if (pop && !push) begin
            count_d = count_q - CW'(1);
        end
    end

    // ready and valid are flops loaded from count_d, so they track count_q with no cycle of lag and no combinational path
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
            empty <= 1'b1;
        end else begin
            count_q <= count_d;
            in_ready <= (count_d < CW'(DEPTH));
            out_valid <= (count_d != '0);
            empty <= (count_d == '0);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + PW'(1);
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + PW'(1);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

endmodule : uart_tx_buffer

// ===== verif/uart_autobaud_break_wakeup_monitor.sv
`timescale 1ns/1ps
`include "uart_ab_params.svh"

module uart_autobaud_break_wakeup_monitor (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic rx_line,
    input wire logic tx_line,
    input wire logic autobaud_arm_clr,
    input wire logic divisor_wr,
    input wire logic receive_data_rd,
    input wire logic wide_divisor_sel,
    input wire logic high_speed_sel,
    input wire logic autobaud_arm,
    input wire logic wake_arm,
    input wire logic break_send,
    input wire logic autobaud_overflow,
    input wire logic receive_flag,
    input wire logic receiver_idle,
    input wire logic [15:0] divisor
);
    // ****************************************************************
    // helpers: bit length and low run on the transmit line
    // ****************************************************************
    logic [4:0] shift;
    logic [31:0] bit_cyc;
    logic [31:0] low_q;
    assign shift = (wide_divisor_sel && high_speed_sel) ? `BASE_SHIFT_FAST :
        (wide_divisor_sel || high_speed_sel) ? `BASE_SHIFT_MID : `BASE_SHIFT_SLOW;
    assign bit_cyc = (32'h0000_0001 + {16'h0000, divisor}) << shift;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            low_q <= '0;
        end else begin
            low_q <= tx_line ? '0 : low_q + 32'h0000_0001;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // ****************************************************************
    // properties
    // ****************************************************************
    property p_arm_done;
        $fell(autobaud_arm) && !$past(autobaud_arm_clr) |-> receive_flag && !$past(receiver_idle);
    endproperty
    a_arm_done: assert property (p_arm_done) else $error("calibration end without flag");
    property p_flag_clear;
        $fell(receive_flag) |-> $past(receive_data_rd);
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("receive flag cleared without read");
    property p_div_hold;
        !autobaud_arm && !divisor_wr |=> $stable(divisor);
    endproperty
    a_div_hold: assert property (p_div_hold) else $error("divisor moved outside calibration");
    property p_ovf;
        $rose(autobaud_overflow) |-> divisor == 16'h0000 && receive_flag;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow without wrap or flag");
    property p_wake_flag;
        wake_arm && $fell(rx_line) |-> ##[1:3] receive_flag;
    endproperty
    a_wake_flag: assert property (p_wake_flag) else $error("wake event gave no flag");
    property p_wake_clear;
        wake_arm && $rose(rx_line) |-> ##[1:3] !wake_arm;
    endproperty
    a_wake_clear: assert property (p_wake_clear) else $error("wake arm kept after break end");
    property p_wake_blocks;
        wake_arm && $past(wake_arm) |-> receiver_idle;
    endproperty
    a_wake_blocks: assert property (p_wake_blocks) else $error("receiver busy while wake armed");
    property p_break_low;
        break_send && $rose(tx_line) |-> low_q == 32'h0000_000d * bit_cyc;
    endproperty
    a_break_low: assert property (p_break_low) else $error("break low time wrong");

    c_cal_done: cover property ($fell(autobaud_arm) && receive_flag);
    c_wake_end: cover property ($fell(wake_arm));
    c_break_end: cover property ($fell(break_send));
endmodule : uart_autobaud_break_wakeup_monitor

bind uart_autobaud_break_wakeup uart_autobaud_break_wakeup_monitor i_monitor (.*);

// ===== verif/serial_node.sv
`timescale 1ns/1ps

module serial_node (
    input wire logic clk_sys,
    output logic rx_line,
    input wire logic tx_line
);
    initial rx_line = 1'b1;

    // ****************************************************************
    // toward the device, lsb first; last bit stays as idle high
    // ****************************************************************
    task automatic send_bits(input logic [15:0] v, input int n, input int bc);
        for (int i = 0; i < n; i++) begin
            rx_line = v[i];
            repeat (bc) @(posedge clk_sys);
            #2;
        end
    endtask : send_bits

    // ****************************************************************
    // from the device; sampled on falling edges, clear of updates
    // ****************************************************************
    task automatic get_frame(input int bc, output int low, output logic [7:0] d);
        int k;
        k = 0;
        low = 0;
        d = 8'h00;
        while (tx_line !== 1'b0 && k < 20000) begin
            @(negedge clk_sys);
            k++;
        end
        if (tx_line === 1'b0) begin
            low = 1;
        end
        for (k = 1; k < 14 * bc - 1; k++) begin
            @(negedge clk_sys);
            if (tx_line === 1'b0 && low == k) begin
                low = k + 1;
            end
            if (k % bc == bc / 2 && k / bc >= 1 && k / bc <= 8) begin
                d[k / bc - 1] = tx_line;
            end
        end
    endtask : get_frame
endmodule : serial_node

// ===== verif/uart_autobaud_break_wakeup_test.sv
`timescale 1ns/1ps

module uart_autobaud_break_wakeup_test;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] ctl = 8'h00;
    logic transmit_enable = 1'b0, wide_divisor_sel = 1'b0, high_speed_sel = 1'b0, tx_valid = 1'b0;
    logic [15:0] divisor_wdata = 16'h0000;
    logic [7:0] tx_data = 8'h00;
    logic rx_line, tx_line, tx_ready, autobaud_arm, wake_arm, break_send, autobaud_overflow;
    logic receive_flag, receiver_idle, shift_empty, transmit_flag;
    logic [15:0] divisor;
    logic [7:0] receive_data_reg, d;
    int n_mismatch = 0, num_checks = 0, seed = 16090, low, bc, dv;

    always #20 clk_sys = ~clk_sys;

    uart_autobaud_break_wakeup i_uart_autobaud_break_wakeup (
        .autobaud_arm_set(ctl[0]), .autobaud_arm_clr(ctl[1]), .wake_arm_set(ctl[2]), .wake_arm_clr(ctl[3]),
        .break_send_set(ctl[4]), .overflow_clr(ctl[5]), .receive_data_rd(ctl[6]), .divisor_wr(ctl[7]), .*
    );
    serial_node i_serial_node (.*);

    // ****************************************************************
    // driving and checking
    // ****************************************************************
    task tick;
        @(posedge clk_sys);
        #2;
    endtask : tick
    task pulse(input int b);
        ctl[b] = 1'b1;
        tick();
        ctl = 8'h00;
        tick();
    endtask : pulse
    task push(input logic [7:0] v);
        tx_valid = 1'b1;
        tx_data = v;
        tick();
        tx_valid = 1'b0;
        tick();
    endtask : push
    task chk_bit(input string n, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %0b seen %0b", n, e, g);
        end
    endtask : chk_bit
    task chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk_word
    task wait_flag;
        int k;
        k = 0;
        while (receive_flag !== 1'b1 && k < 20000) begin
            tick();
            k++;
        end
        chk_bit("receive_flag", 1'b1, receive_flag);
    endtask : wait_flag
    task close_out;
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    // watchdog
    initial begin
        repeat (80000) @(posedge clk_sys);
        n_mismatch++;
        close_out();
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        #2;
        rst_b = 1'b1;
        tick();
        chk_word("reset outputs", 16'h03e0, {6'h00, tx_line, tx_ready, transmit_flag, shift_empty,
            receiver_idle, receive_flag, autobaud_arm, wake_arm, break_send, autobaud_overflow});
        chk_word("divisor", 16'h0000, divisor);
        for (int b = 0; b < 4; b += 2) begin
            pulse(b);
            chk_bit("arm set", 1'b1, b == 0 ? autobaud_arm : wake_arm);
            pulse(b + 1);
            chk_bit("arm clear", 1'b0, b == 0 ? autobaud_arm : wake_arm);
        end
        pulse(5);
        chk_bit("autobaud_overflow", 1'b0, autobaud_overflow);
        // calibration for every select pair; 8.5 ticks between first and fifth rise
        for (int s = 0; s < 4; s++) begin
            wide_divisor_sel = s[0];
            high_speed_sel = s[1];
            bc = (8 << (6 - 2 * (s[0] + s[1]))) * 17 / 16;
            pulse(0);
            i_serial_node.send_bits(16'h02aa, 10, bc);
            wait_flag();
            chk_word("divisor", 16'h0009, divisor);
            chk_bit("autobaud_arm", 1'b0, autobaud_arm);
            pulse(6);
            chk_bit("receive_flag", 1'b0, receive_flag);
        end
        // normal reception, first byte right after an early disarm
        for (int i = 0; i < 5; i++) begin
            dv = ($random(seed) & 3) + 2;
            divisor_wdata = dv[15:0];
            pulse(7);
            bc = (dv + 1) * 4;
            d = i == 1 ? 8'h00 : i == 2 ? 8'hff : $random(seed);
            if (i == 0) begin
                pulse(0);
                pulse(1);
            end
            i_serial_node.send_bits({7'h01, d, 1'b0}, 10, bc);
            wait_flag();
            chk_word("receive_data_reg", {8'h00, d}, {8'h00, receive_data_reg});
            pulse(6);
        end
        // wake on break; idle checked first as software would
        chk_bit("receiver_idle", 1'b1, receiver_idle);
        pulse(2);
        fork
            i_serial_node.send_bits(16'h2000, 14, bc);
            begin
                wait_flag();
                chk_bit("wake_arm", 1'b1, wake_arm);
            end
        join
        chk_bit("wake_arm", 1'b0, wake_arm);
        pulse(6);
        chk_bit("receive_flag", 1'b0, receive_flag);
        // both armed: sync after the break is measured
        pulse(2);
        pulse(0);
        fork
            i_serial_node.send_bits(16'h2000, 14, bc);
            begin
                wait_flag();
                pulse(6);
            end
        join
        chk_bit("autobaud_arm", 1'b1, autobaud_arm);
        i_serial_node.send_bits(16'h02aa, 10, 34);
        wait_flag();
        chk_word("divisor", 16'h0009, divisor);
        pulse(6);
        // header: break then sync, buffer filled while transmitter held off
        dv = ($random(seed) & 3) + 2;
        divisor_wdata = dv[15:0];
        pulse(7);
        bc = (dv + 1) * 4;
        pulse(4);
        push($random(seed));
        push(8'h55);
        chk_bit("tx_ready", 1'b0, tx_ready);
        chk_bit("transmit_flag", 1'b0, transmit_flag);
        transmit_enable = 1'b1;
        i_serial_node.get_frame(bc, low, d);
        chk_word("break low", 16'(13 * bc), 16'(low));
        i_serial_node.get_frame(bc, low, d);
        chk_word("sync low", 16'(bc), 16'(low));
        chk_word("sync data", 16'h0055, {8'h00, d});
        chk_bit("break_send", 1'b0, break_send);
        chk_word("tx idle", 16'h0007, {13'h0000, shift_empty, transmit_flag, tx_ready});
        close_out();
    end
endmodule : uart_autobaud_break_wakeup_test
